// *** twu_consts.svh ***
// Purpose: Offsets, field positions, reset values, status codes and timing for the two-wire unit
// Assumes: Byte addresses on a 32-bit Avalon-MM slave, one register per aligned word
// Notes:   Definitions only
`ifndef TWU_CONSTS_SVH
`define TWU_CONSTS_SVH
// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define TWU_OFS_RATE 8'hB8
`define TWU_OFS_CTRL 8'hBC
`define TWU_OFS_STAT 8'hC0
`define TWU_OFS_DATA 8'hC4
`define TWU_OFS_OWN 8'hC8
// ----------------------------------------
// Control field positions
// ----------------------------------------
`define TWU_BIT_DONE 7
`define TWU_BIT_ACKEN 6
`define TWU_BIT_START 5
`define TWU_BIT_STOP 4
`define TWU_BIT_WCOL 3
`define TWU_BIT_EN 2
`define TWU_BIT_IRQEN 0
// ----------------------------------------
// Reset values and timing
// ----------------------------------------
`define TWU_RST_RATE 8'h00
`define TWU_RST_DATA 8'hFF
`define TWU_RST_OWN 8'h00
`define TWU_HALF_BASE 16'h0008
// ----------------------------------------
// Status codes (low three bits always zero)
// ----------------------------------------
`define TWU_SC_BUSERR 8'h00
`define TWU_SC_START 8'h08
`define TWU_SC_RSTART 8'h10
`define TWU_SC_MT_AW_ACK 8'h18
`define TWU_SC_MT_AW_NACK 8'h20
`define TWU_SC_MT_D_ACK 8'h28
`define TWU_SC_MT_D_NACK 8'h30
`define TWU_SC_ARB_LOST 8'h38
`define TWU_SC_MR_AR_ACK 8'h40
`define TWU_SC_MR_AR_NACK 8'h48
`define TWU_SC_MR_D_ACK 8'h50
`define TWU_SC_MR_D_NACK 8'h58
`define TWU_SC_SLRX_ADDR 8'h60
`define TWU_SC_SLRX_ADDR_ARB 8'h68
`define TWU_SC_SLRX_GC 8'h70
`define TWU_SC_SLRX_GC_ARB 8'h78
`define TWU_SC_SLRX_D_ACK 8'h80
`define TWU_SC_SLRX_D_NACK 8'h88
`define TWU_SC_SLRX_GD_ACK 8'h90
`define TWU_SC_SLRX_GD_NACK 8'h98
`define TWU_SC_SLRX_STOP 8'hA0
`define TWU_SC_SLTX_ADDR 8'hA8
`define TWU_SC_SLTX_ADDR_ARB 8'hB0
`define TWU_SC_SLTX_D_ACK 8'hB8
`define TWU_SC_SLTX_D_NACK 8'hC0
`define TWU_SC_SLTX_LAST 8'hC8
`define TWU_SC_IDLE 8'hF8
`endif

// *** twu_pkg.sv ***
// Purpose: Types shared by the two-wire unit
// Assumes: Nothing beyond the language
// Notes:   Constants live in twu_consts.svh
package twu_pkg;
	// Protocol engine states
	typedef enum logic [2:0] {
		eng_off,
		eng_idle,
		eng_mstart,
		eng_xfer,
		eng_wait,
		eng_mstop
	} twu_state_type;
endpackage : twu_pkg

// *** twu_core.sv ***
// Purpose: Two-wire serial unit with multi-master arbitration, master and slave byte engine
// Assumes: 50 MHz clk, synchronous active-high rst, open-drain pins resolved outside
// Notes:   Function
// Function
// - Lose arbitration on driven one read zero
// - Data or direction loss: idle or restart
// - Address loss: check own address, become slave
// - Identical transfers complete with no loss
// - Rate divider sets master clock division
// - Set job-done flag; interrupt with enables
// - Hold clock low while job-done set
// - Job-done clears by writing one, resumes
// - Ack enable drives acknowledge when addressed
// - Ack enable cleared detaches from bus
// - Start request waits for free bus
// - Master stop request sends stop, self-clears
// - Slave stop request releases lines, no stop
// - Data write while busy flags collision
// - Interface enable owns pins, clear aborts
// - Reserved control and status bits read zero
// - Interrupt held while job-done and enables
// - Status code in bits seven to three
// - Prescaler select decodes one, four, sixteen, sixtyfour
// - Code F8 whenever job-done is clear
// - Misplaced start or stop when not master gives code 00
// - Compare against seven-bit own address
`timescale 1ns/1ns
`include "twu_consts.svh"
module twu_core (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Avalon-MM register slave
	input wire logic [7:0] avs_address,
	input wire logic [3:0] avs_byteenable,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	// Processor side interrupt
	input wire logic cpu_irq_global,
	output logic irq,
	// Open-drain clock pin
	input wire logic scl_in,
	output logic scl_out,
	output logic scl_oe,
	// Open-drain data pin
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe
);
	// ----------------------------------------
	// Declarations
	// ----------------------------------------
	logic [7:0] bit_rate_divider; // Rate divider register
	logic [1:0] rate_prescaler_select; // Prescaler field
	logic [7:0] own_address_register; // Own address plus general call enable
	logic [7:0] data_byte_register; // Last byte on the bus or next to send
	logic job_done_flag; // Waiting for software
	logic ack_enable; // Acknowledge enable
	logic start_request; // Start wanted
	logic stop_request; // Stop wanted
	logic write_collision_flag; // Data written while busy
	logic interface_enable; // Unit on
	logic irq_enable; // Interrupt enable
	twu_pkg::twu_state_type state; // Engine state
	logic [7:0] status_code; // Last status, low bits zero
	logic done_set; // Engine pulse: set job-done
	logic stop_clr; // Engine pulse: clear stop request
	logic is_master; // Owns the bus
	logic addr_phase; // Current byte is an address
	logic tx_mode; // We shift data out
	logic rw_bit; // Direction bit of the address
	logic gc_mode; // Addressed by general call
	logic arb_lost; // Arbitration lost in this byte
	logic last_tx; // Slave sends its last byte
	logic end_xfer; // Go idle after the wait
	logic ack_out; // We acknowledge this byte
	logic ack_in; // Receiver acknowledged
	logic got_rise; // Clock rose in this bit
	logic [3:0] bit_cnt; // Bit index, 8 is the ack bit
	logic [1:0] step; // Start or stop sub-step
	logic [15:0] tmr; // Half-period timer
	logic [15:0] half_cnt; // Half-period length
	logic tmr_done; // Half period elapsed
	logic [7:0] tx_shift; // Outgoing shifter
	logic [7:0] rx_shift; // Incoming shifter
	logic bus_busy; // Start seen without stop
	logic [1:0] pin_m; // First sync stage
	logic [1:0] pin_s; // Second sync stage
	logic [1:0] pin_t; // Filter sample
	logic [1:0] pin_f; // Filtered levels, bit 1 clock
	logic [1:0] pin_p; // Previous filtered levels
	logic scl_f; // Filtered clock
	logic sda_f; // Filtered data
	logic scl_rise; // Clock rose
	logic scl_fall; // Clock fell
	logic start_det; // Start seen on bus
	logic stop_det; // Stop seen on bus
	logic go_slave; // Enter address reception
	logic own_match; // Own address hit
	logic gc_match; // General call hit
	logic acc; // Bus write completes now
	logic wr_ctrl; // Control write
	logic wr_data; // Data write
	logic [7:0] rd_mux; // Read value
	logic [7:0] stat_rd; // Status as read
	logic [7:0] wd; // Write byte

	// ----------------------------------------
	// Pin synchroniser and spike filter
	// ----------------------------------------
	// Two flops, then a level must repeat before it is taken
	always_ff @(posedge clk) begin
		if (rst) begin
			pin_m <= 2'h3;
			pin_s <= 2'h3;
			pin_t <= 2'h3;
			pin_f <= 2'h3;
			pin_p <= 2'h3;
		end else begin
			pin_m <= {scl_in, sda_in};
			pin_s <= pin_m;
			pin_t <= pin_s;
			pin_f <= (pin_s & pin_t) | (pin_f & (pin_s ^ pin_t));
			pin_p <= pin_f;
		end
	end

	assign scl_f = pin_f[1];
	assign sda_f = pin_f[0];
	assign scl_rise = scl_f && !pin_p[1];
	assign scl_fall = !scl_f && pin_p[1];
	assign start_det = scl_f && pin_p[1] && pin_p[0] && !sda_f;
	assign stop_det = scl_f && pin_p[1] && !pin_p[0] && sda_f;

	// Bus free tracking
	always_ff @(posedge clk) begin
		if (rst || !interface_enable) begin
			bus_busy <= 1'b0;
		end else if (start_det) begin
			bus_busy <= 1'b1;
		end else if (stop_det) begin
			bus_busy <= 1'b0;
		end
	end

	// ----------------------------------------
	// Bit rate
	// ----------------------------------------
	// Half period is 8 plus divider times prescaler
	always_comb begin
		unique case (rate_prescaler_select)
			2'h0: half_cnt = `TWU_HALF_BASE + {8'h00, bit_rate_divider};
			2'h1: half_cnt = `TWU_HALF_BASE + {6'h00, bit_rate_divider, 2'h0};
			2'h2: half_cnt = `TWU_HALF_BASE + {4'h0, bit_rate_divider, 4'h0};
			2'h3: half_cnt = `TWU_HALF_BASE + {2'h0, bit_rate_divider, 6'h00};
		endcase
	end

	assign tmr_done = (tmr >= half_cnt - 16'h0001);

	// Address comparators
	assign own_match = ack_enable && (rx_shift[7:1] == own_address_register[7:1]);
	assign gc_match = ack_enable && own_address_register[0] && (rx_shift[7:1] == 7'h00);

	// Start seen where an address may begin
	assign go_slave = start_det && ((state == twu_pkg::eng_idle)
		|| (state == twu_pkg::eng_mstart && !step[1] && !is_master)
		|| (state == twu_pkg::eng_xfer && !is_master && addr_phase && bit_cnt == 4'h0 && !got_rise));

	// ----------------------------------------
	// Protocol engine
	// ----------------------------------------
	always_ff @(posedge clk) begin
		if (rst) begin
			state <= twu_pkg::eng_off;
			status_code <= `TWU_SC_IDLE;
			done_set <= 1'b0;
			stop_clr <= 1'b0;
			is_master <= 1'b0;
			addr_phase <= 1'b0;
			tx_mode <= 1'b0;
			rw_bit <= 1'b0;
			gc_mode <= 1'b0;
			arb_lost <= 1'b0;
			last_tx <= 1'b0;
			end_xfer <= 1'b0;
			ack_out <= 1'b0;
			ack_in <= 1'b0;
			got_rise <= 1'b0;
			bit_cnt <= 4'h0;
			step <= 2'h0;
			tmr <= 16'h0000;
			tx_shift <= `TWU_RST_DATA;
			rx_shift <= `TWU_RST_DATA;
			data_byte_register <= `TWU_RST_DATA;
			scl_oe <= 1'b0;
			sda_oe <= 1'b0;
		end else if (!interface_enable) begin
			// Unit off: abort everything, let go of the pins
			state <= twu_pkg::eng_off;
			is_master <= 1'b0;
			done_set <= 1'b0;
			stop_clr <= 1'b0;
			scl_oe <= 1'b0;
			sda_oe <= 1'b0;
			if (wr_data && job_done_flag) begin
				data_byte_register <= wd;
			end
		end else begin
			done_set <= 1'b0;
			stop_clr <= 1'b0;
			if (go_slave) begin
				// Receive an address as slave
				state <= twu_pkg::eng_xfer;
				is_master <= 1'b0;
				tx_mode <= 1'b0;
				addr_phase <= 1'b1;
				arb_lost <= 1'b0;
				bit_cnt <= 4'h0;
				got_rise <= 1'b0;
				scl_oe <= 1'b0;
				sda_oe <= 1'b0;
			end else begin
				unique case (state)
					twu_pkg::eng_off: begin
						state <= twu_pkg::eng_idle;
					end
					twu_pkg::eng_idle: begin
						// Start is not cleared here; software drops it
						if (start_request && !job_done_flag && !bus_busy) begin
							state <= twu_pkg::eng_mstart;
							step <= 2'h0;
							tmr <= 16'h0000;
						end
					end
					twu_pkg::eng_mstart, twu_pkg::eng_mstop: begin
						// Timed edges of start or stop
						if (step == 2'h1 && !scl_f) begin
							tmr <= 16'h0000;
						end else if (!tmr_done) begin
							tmr <= tmr + 16'h0001;
						end else begin
							tmr <= 16'h0000;
							step <= step + 2'h1;
							if (state == twu_pkg::eng_mstart) begin
								unique case (step)
									2'h0: scl_oe <= 1'b0;
									2'h1: sda_oe <= 1'b1;
									2'h2: scl_oe <= 1'b1;
									2'h3: begin
										// Start sent, now master
										status_code <= is_master ? `TWU_SC_RSTART : `TWU_SC_START;
										is_master <= 1'b1;
										addr_phase <= 1'b1;
										arb_lost <= 1'b0;
										end_xfer <= 1'b0;
										done_set <= 1'b1;
										state <= twu_pkg::eng_wait;
									end
								endcase
							end else begin
								unique case (step)
									2'h0: scl_oe <= 1'b0;
									2'h1: sda_oe <= 1'b0;
									2'h2: begin
										// Stop done: clear request, back to slave
										stop_clr <= 1'b1;
										is_master <= 1'b0;
										state <= twu_pkg::eng_idle;
									end
									2'h3: state <= twu_pkg::eng_idle;
								endcase
							end
						end
					end
					twu_pkg::eng_wait: begin
						// Clock held low until software clears job-done
						if (!job_done_flag && !done_set) begin
							tmr <= 16'h0000;
							step <= 2'h0;
							if (stop_request && is_master) begin
								state <= twu_pkg::eng_mstop;
								sda_oe <= 1'b1;
							end else if (stop_request) begin
								// Slave recovery: release lines, no stop on bus
								stop_clr <= 1'b1;
								scl_oe <= 1'b0;
								sda_oe <= 1'b0;
								state <= twu_pkg::eng_idle;
							end else if (start_request && is_master) begin
								state <= twu_pkg::eng_mstart;
								sda_oe <= 1'b0;
							end else if (end_xfer) begin
								// Not addressed slave; idle retries any start
								scl_oe <= 1'b0;
								sda_oe <= 1'b0;
								is_master <= 1'b0;
								state <= twu_pkg::eng_idle;
							end else begin
								// Next byte
								state <= twu_pkg::eng_xfer;
								bit_cnt <= 4'h0;
								got_rise <= 1'b0;
								tx_shift <= data_byte_register;
								last_tx <= !ack_enable;
								tx_mode <= is_master ? (addr_phase || !rw_bit) : rw_bit;
								sda_oe <= (is_master ? (addr_phase || !rw_bit) : rw_bit) && !data_byte_register[7];
								scl_oe <= is_master;
							end
						end else begin
							scl_oe <= 1'b1;
						end
					end
					twu_pkg::eng_xfer: begin
						if ((start_det || stop_det) && !is_master) begin
							if (bit_cnt != 4'h0 || got_rise) begin
								// Misplaced start or stop
								status_code <= `TWU_SC_BUSERR;
								end_xfer <= 1'b1;
							end else begin
								// Stop or restart while addressed
								status_code <= `TWU_SC_SLRX_STOP;
								end_xfer <= 1'b1;
							end
							if (addr_phase && !(bit_cnt != 4'h0 || got_rise)) begin
								state <= twu_pkg::eng_idle;
							end else begin
								done_set <= 1'b1;
								state <= twu_pkg::eng_wait;
								sda_oe <= 1'b0;
								scl_oe <= 1'b1;
							end
						end else begin
							// Master clock: low half, release, high half after stretch
							if (is_master) begin
								if (scl_oe) begin
									if (tmr_done) begin
										scl_oe <= 1'b0;
										tmr <= 16'h0000;
									end else begin
										tmr <= tmr + 16'h0001;
									end
								end else if (scl_f) begin
									if (tmr_done) begin
										scl_oe <= 1'b1;
										tmr <= 16'h0000;
									end else begin
										tmr <= tmr + 16'h0001;
									end
								end
							end
							if (scl_rise) begin
								got_rise <= 1'b1;
								if (bit_cnt == 4'h8) begin
									ack_in <= !sda_f;
								end else begin
									rx_shift <= {rx_shift[6:0], sda_f};
									// Only a released one read back as zero loses
									if (is_master && tx_mode && !sda_oe && !sda_f) begin
										is_master <= 1'b0;
										arb_lost <= 1'b1;
										tx_mode <= 1'b0;
										scl_oe <= 1'b0;
									end
								end
							end
							if (scl_fall) begin
								got_rise <= 1'b0;
								if (bit_cnt == 4'h7) begin
									bit_cnt <= 4'h8;
									if (tx_mode) begin
										sda_oe <= 1'b0;
										ack_out <= 1'b0;
									end else if (addr_phase && !is_master) begin
										// Slave address check, also after a loss
										sda_oe <= own_match || gc_match;
										ack_out <= own_match || gc_match;
										gc_mode <= gc_match && !own_match;
										rw_bit <= rx_shift[0];
									end else if (!arb_lost) begin
										sda_oe <= ack_enable;
										ack_out <= ack_enable;
									end else begin
										sda_oe <= 1'b0;
										ack_out <= 1'b0;
									end
								end else if (bit_cnt == 4'h8) begin
									// Byte finished
									bit_cnt <= 4'h0;
									sda_oe <= 1'b0;
									scl_oe <= 1'b1;
									data_byte_register <= rx_shift;
									addr_phase <= 1'b0;
									arb_lost <= 1'b0;
									end_xfer <= 1'b0;
									done_set <= 1'b1;
									state <= twu_pkg::eng_wait;
									if (is_master) begin
										if (addr_phase) begin
											rw_bit <= rx_shift[0];
											if (rx_shift[0]) begin
												status_code <= ack_in ? `TWU_SC_MR_AR_ACK : `TWU_SC_MR_AR_NACK;
											end else begin
												status_code <= ack_in ? `TWU_SC_MT_AW_ACK : `TWU_SC_MT_AW_NACK;
											end
										end else if (tx_mode) begin
											status_code <= ack_in ? `TWU_SC_MT_D_ACK : `TWU_SC_MT_D_NACK;
										end else begin
											status_code <= ack_out ? `TWU_SC_MR_D_ACK : `TWU_SC_MR_D_NACK;
										end
									end else if (arb_lost && !ack_out) begin
										status_code <= `TWU_SC_ARB_LOST;
										end_xfer <= 1'b1;
									end else if (addr_phase) begin
										if (!ack_out) begin
											// Not for us: no flag, let go
											done_set <= 1'b0;
											scl_oe <= 1'b0;
											state <= twu_pkg::eng_idle;
										end else if (rw_bit) begin
											status_code <= arb_lost ? `TWU_SC_SLTX_ADDR_ARB : `TWU_SC_SLTX_ADDR;
										end else if (gc_mode) begin
											status_code <= arb_lost ? `TWU_SC_SLRX_GC_ARB : `TWU_SC_SLRX_GC;
										end else begin
											status_code <= arb_lost ? `TWU_SC_SLRX_ADDR_ARB : `TWU_SC_SLRX_ADDR;
										end
									end else if (tx_mode) begin
										if (!ack_in) begin
											status_code <= `TWU_SC_SLTX_D_NACK;
										end else begin
											status_code <= last_tx ? `TWU_SC_SLTX_LAST : `TWU_SC_SLTX_D_ACK;
										end
										end_xfer <= !ack_in || last_tx;
									end else begin
										if (gc_mode) begin
											status_code <= ack_out ? `TWU_SC_SLRX_GD_ACK : `TWU_SC_SLRX_GD_NACK;
										end else begin
											status_code <= ack_out ? `TWU_SC_SLRX_D_ACK : `TWU_SC_SLRX_D_NACK;
										end
										end_xfer <= !ack_out;
									end
								end else begin
									// Next data bit
									bit_cnt <= bit_cnt + 4'h1;
									if (tx_mode) begin
										sda_oe <= !tx_shift[6];
										tx_shift <= {tx_shift[6:0], 1'b1};
									end
								end
							end
						end
					end
				endcase
			end
			// Software load of the data byte, only while waiting
			if (wr_data && job_done_flag) begin
				data_byte_register <= wd;
			end
		end
	end

	// ----------------------------------------
	// Register bus
	// ----------------------------------------
	assign acc = avs_write && !avs_waitrequest;
	assign wd = avs_writedata[7:0];
	assign wr_ctrl = acc && avs_byteenable[0] && (avs_address == `TWU_OFS_CTRL);
	assign wr_data = acc && avs_byteenable[0] && (avs_address == `TWU_OFS_DATA);
	assign stat_rd = job_done_flag ? status_code : `TWU_SC_IDLE;

	// Read mux, unmapped reads zero
	always_comb begin
		unique case (avs_address)
			`TWU_OFS_RATE: rd_mux = bit_rate_divider;
			`TWU_OFS_CTRL: rd_mux = {job_done_flag, ack_enable, start_request, stop_request,
				write_collision_flag, interface_enable, 1'b0, irq_enable};
			`TWU_OFS_STAT: rd_mux = {stat_rd[7:3], 1'b0, rate_prescaler_select};
			`TWU_OFS_DATA: rd_mux = data_byte_register;
			`TWU_OFS_OWN: rd_mux = own_address_register;
			default: rd_mux = 8'h00;
		endcase
	end

	// One wait state per access
	always_ff @(posedge clk) begin
		if (rst) begin
			avs_waitrequest <= 1'b1;
			avs_readdata <= 32'h00000000;
		end else begin
			avs_waitrequest <= !((avs_read || avs_write) && avs_waitrequest);
			if (avs_read && avs_waitrequest) begin
				avs_readdata <= {24'h000000, rd_mux};
			end
		end
	end

	// Rate, prescaler and own address
	always_ff @(posedge clk) begin
		if (rst) begin
			bit_rate_divider <= `TWU_RST_RATE;
			rate_prescaler_select <= 2'h0;
			own_address_register <= `TWU_RST_OWN;
		end else if (acc && avs_byteenable[0]) begin
			if (avs_address == `TWU_OFS_RATE) begin
				bit_rate_divider <= wd;
			end
			if (avs_address == `TWU_OFS_STAT) begin
				rate_prescaler_select <= wd[1:0];
			end
			if (avs_address == `TWU_OFS_OWN) begin
				own_address_register <= wd;
			end
		end
	end

	// Control bits; hardware set of job-done wins over the clear
	always_ff @(posedge clk) begin
		if (rst) begin
			job_done_flag <= 1'b0;
			ack_enable <= 1'b0;
			start_request <= 1'b0;
			stop_request <= 1'b0;
			interface_enable <= 1'b0;
			irq_enable <= 1'b0;
		end else begin
			if (wr_ctrl) begin
				ack_enable <= wd[`TWU_BIT_ACKEN];
				start_request <= wd[`TWU_BIT_START];
				interface_enable <= wd[`TWU_BIT_EN];
				irq_enable <= wd[`TWU_BIT_IRQEN];
			end
			if (stop_clr) begin
				stop_request <= 1'b0;
			end
			if (wr_ctrl) begin
				stop_request <= wd[`TWU_BIT_STOP];
			end
			if (wr_ctrl && wd[`TWU_BIT_DONE]) begin
				job_done_flag <= 1'b0;
			end
			if (done_set) begin
				job_done_flag <= 1'b1;
			end
		end
	end

	// Write collision on data writes
	always_ff @(posedge clk) begin
		if (rst) begin
			write_collision_flag <= 1'b0;
		end else if (wr_data) begin
			write_collision_flag <= !job_done_flag;
		end
	end

	// Interrupt request and open-drain low levels
	always_ff @(posedge clk) begin
		if (rst) begin
			irq <= 1'b0;
			scl_out <= 1'b0;
			sda_out <= 1'b0;
		end else begin
			irq <= job_done_flag && irq_enable && cpu_irq_global;
			scl_out <= 1'b0;
			sda_out <= 1'b0;
		end
	end
endmodule : twu_core

// *** twu_sva.sv ***
// Purpose: Bus and pin checks for twu_core
// Assumes: Sees top ports only
// Notes: Bound from the bench top file
`timescale 1ns/1ns
`include "twu_consts.svh"
module twu_sva (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Register bus
	input wire logic [7:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [31:0] avs_readdata,
	input wire logic avs_waitrequest,
	// Interrupt and pins
	input wire logic cpu_irq_global,
	input wire logic irq,
	input wire logic scl_out,
	input wire logic scl_oe,
	input wire logic sda_out,
	input wire logic sda_oe
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	// Read accepted this edge
	logic rd_ok;
	assign rd_ok = avs_read && !avs_waitrequest;
	a_wait_fall: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
		else $error("request not answered");
	a_wait_once: assert property (!avs_waitrequest |=> avs_waitrequest) else $error("wait low twice");
	a_upper_zero: assert property (rd_ok |-> avs_readdata[31:8] == 24'h0) else $error("upper bits set");
	a_rsvd_ctrl: assert property (rd_ok && avs_address == `TWU_OFS_CTRL |-> !avs_readdata[1])
		else $error("control bit 1 set");
	a_rsvd_stat: assert property (rd_ok && avs_address == `TWU_OFS_STAT |-> !avs_readdata[2])
		else $error("status bit 2 set");
	a_unmapped_zero: assert property (rd_ok && !(avs_address inside {`TWU_OFS_RATE, `TWU_OFS_CTRL,
		`TWU_OFS_STAT, `TWU_OFS_DATA, `TWU_OFS_OWN}) |-> avs_readdata == 32'h0) else $error("unmapped read");
	a_irq_gate: assert property (irq |-> $past(cpu_irq_global)) else $error("irq without global");
	a_pins_low: assert property (!scl_out && !sda_out) else $error("pin driven high");
	a_off_release: assert property (avs_write && !avs_waitrequest && avs_address == `TWU_OFS_CTRL
		&& !avs_writedata[2] |-> ##[1:4] (!scl_oe && !sda_oe)) else $error("pins kept");
	// Main scenarios
	c_irq: cover property ($rose(irq));
	c_ack: cover property ($rose(sda_oe));
	c_stretch: cover property (irq && scl_oe);
endmodule : twu_sva

// *** twu_slave_model.sv ***
// Purpose: Bus slave that acknowledges its address byte
// Assumes: Resolved wire levels
// Notes: No clock stretching
`timescale 1ns/1ns
module twu_slave_model #(parameter logic [6:0] ADDR = 7'h50) (
	// Bus wires
	input wire logic scl,
	input wire logic sda,
	output logic sda_oe
);
	int n; // Bits seen
	logic [7:0] sh; // Address shifter
	logic act; // Inside a frame
	initial begin
		sda_oe = 1'b0;
		act = 1'b0;
	end
	// Start and stop
	always @(negedge sda) if (scl) begin
		n = 0;
		act = 1'b1;
	end
	always @(posedge sda) if (scl) act = 1'b0;
	// Sample on clock rise
	always @(posedge scl) if (act && n < 8) begin
		sh = {sh[6:0], sda};
		n++;
	end
	// Ack own address, then go quiet
	always @(negedge scl) if (act) begin
		if (n == 8 && sh[7:1] == ADDR) begin
			sda_oe <= 1'b1;
			n = 9;
		end else if (n >= 8) begin
			sda_oe <= 1'b0;
			act = 1'b0;
		end
	end
endmodule : twu_slave_model

// *** twu_core_tb.sv ***
// Purpose: Register and master flow bench for twu_core
// Assumes: One wait state bus, pull-ups on both wires
// Notes: Slave model at address 0x50
`timescale 1ns/1ns
`include "twu_consts.svh"
module twu_core_tb;
	logic clk, rst, avs_read, avs_write, glb, scl_out, scl_oe, sda_out, sda_oe, s_oe, irq, avs_waitrequest;
	logic [7:0] avs_address;
	logic [31:0] avs_writedata, avs_readdata, d;
	wire scl = !scl_oe; // Pull-up wires
	wire sda = !(sda_oe || s_oe);
	int err_total, n_checks, cyc;
	twu_core dut (.clk, .rst, .avs_address, .avs_byteenable(4'hF), .avs_read, .avs_write, .avs_writedata,
		.avs_readdata, .avs_waitrequest, .cpu_irq_global(glb), .irq, .scl_in(scl), .scl_out, .scl_oe,
		.sda_in(sda), .sda_out, .sda_oe);
	twu_slave_model slv (.scl, .sda, .sda_oe(s_oe));
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	// Hang guard
	always @(posedge clk) begin
		cyc++;
		if (cyc == 30000) begin
			err_total++;
			summarize();
		end
	end
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_checks++;
		if (g !== e) begin
			err_total++;
			$display("unexpected %s exp %h got %h", nm, e, g);
		end
	endtask : chk
	// Bus cycles, held until waitrequest low
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		avs_address <= a;
		avs_writedata <= {24'h0, v};
		avs_write <= 1'b1;
		@(posedge clk);
		while (avs_waitrequest) @(posedge clk);
		avs_write <= 1'b0;
		@(posedge clk);
	endtask : wr
	// Plain read into d, no compare
	task automatic rd(input logic [7:0] a);
		avs_address <= a;
		avs_read <= 1'b1;
		@(posedge clk);
		while (avs_waitrequest) @(posedge clk);
		d = avs_readdata;
		avs_read <= 1'b0;
		@(posedge clk);
	endtask : rd
	task automatic rc(input logic [7:0] a, input logic [7:0] e);
		rd(a);
		chk($sformatf("reg %h", a), {24'h0, e}, d);
	endtask : rc
	task automatic wirq();
		repeat (2) @(posedge clk);
		for (int i = 0; i < 5000 && irq !== 1'b1; i++) @(posedge clk);
		chk("irq", 1, irq);
	endtask : wirq
	task automatic summarize();
		$display("checks %0d mismatches %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask : summarize
	initial begin
		{rst, glb} = 2'b11;
		{avs_read, avs_write, avs_address, avs_writedata} = '0;
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		rc(`TWU_OFS_RATE, 8'h00);
		rc(`TWU_OFS_CTRL, 8'h00);
		rc(`TWU_OFS_STAT, 8'hF8);
		rc(`TWU_OFS_DATA, 8'hFF);
		rc(`TWU_OFS_OWN, 8'h00);
		rc(8'h00, 8'h00);
		$display("test reset values done");
		wr(`TWU_OFS_STAT, 8'hFF);
		rc(`TWU_OFS_STAT, 8'hFB);
		wr(`TWU_OFS_DATA, 8'h12);
		rc(`TWU_OFS_DATA, 8'hFF);
		rc(`TWU_OFS_CTRL, 8'h08);
		wr(`TWU_OFS_RATE, 8'h02);
		wr(`TWU_OFS_STAT, 8'h01);
		rc(`TWU_OFS_RATE, 8'h02);
		$display("test fields done");
		wr(`TWU_OFS_CTRL, 8'hA5);
		wirq();
		rc(`TWU_OFS_STAT, 8'h09);
		rc(`TWU_OFS_CTRL, 8'hAD);
		wr(`TWU_OFS_DATA, 8'hA0);
		rc(`TWU_OFS_CTRL, 8'hA5);
		chk("scl", 0, scl);
		wr(`TWU_OFS_CTRL, 8'h85);
		wirq();
		rc(`TWU_OFS_STAT, 8'h19);
		glb <= 1'b0;
		repeat (3) @(posedge clk);
		chk("irq", 0, irq);
		wr(`TWU_OFS_CTRL, 8'h95);
		for (int i = 0; i < 200; i++) begin
			rd(`TWU_OFS_CTRL);
			if (d[4] === 1'b0) break;
		end
		rc(`TWU_OFS_CTRL, 8'h05);
		rc(`TWU_OFS_STAT, 8'hF9);
		chk("sda", 1, sda);
		wr(`TWU_OFS_CTRL, 8'h00);
		repeat (5) @(posedge clk);
		$display("test master flow done");
		summarize();
	end
endmodule : twu_core_tb
bind twu_core twu_sva chk_i (.clk, .rst, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_readdata,
	.avs_waitrequest, .cpu_irq_global, .irq, .scl_out, .scl_oe, .sda_out, .sda_oe);
